//--- ltmc_top.sv
`timescale 1ns/100ps
// Purpose: mode control and data path of one single-wire link transceiver
// Assumes: host writes mode bits with a one-cycle strobe; bus level arrives on a pin
// Notes: no software registers; mode bits are plain ports
module ltmc_top
  import ltmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // chip state and mode command
  input  wire logic [1:0] chip_mode,
  input  wire logic       mode_wr,
  input  wire logic [1:0] mode_wdata,
  output logic      [1:0] mode_bits,
  // host data pins
  input  wire logic       lin_transmit_input,
  output logic            lin_receive_output,
  // bus pins
  input  wire logic       bus_in,
  output logic            bus_out,
  output logic            bus_oe,
  // status
  output logic            wake_pulse,
  output logic            enabled
);
  ltmc_mode_t       mode;
  logic [1:0]       tx_sync;
  logic [1:0]       bus_sync;
  logic [CNT_W-1:0] en_cnt;
  logic             tx_block;
  logic [CNT_W-1:0] wk_cnt;
  logic             wk_armed;
  logic             wk_long;
  logic             woken;
  logic             accept;
  ltmc_filt_if      fif ();

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // both pins idle high, so reset to high to avoid a false edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_sync  <= 2'h3;
      bus_sync <= 2'h3;
    end
    else if (ce)
    begin
      tx_sync  <= {tx_sync[0], lin_transmit_input};
      bus_sync <= {bus_sync[0], bus_in};
    end
  end

  assign fif.raw = bus_sync[1];

  ltmc_noise_filter u_filt (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .f   (fif.filt)
  );

  ////////////////////////////////////////////////////////////////////////
  // mode command check
  always_comb
  begin
    accept = 1'b0;
    case (ltmc_mode_t'(mode_wdata))
      // [R2] off always allowed
      LTMC_OFF:     accept = 1'b1;
      // [R4] normal only in chip normal mode
      LTMC_NORMAL:  accept = (chip_mode == LTMC_CHIP_NORMAL);
      // [R11] receive-only in normal and stop
      LTMC_RX_ONLY: accept = (chip_mode == LTMC_CHIP_NORMAL) || (chip_mode == LTMC_CHIP_STOP);
      // wake-capable kept open in every chip mode
      LTMC_WAKE:    accept = 1'b1;
      default:      accept = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // [R10] mode bits, [R1] off after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode <= LTMC_OFF;
    else if (ce && mode_wr && accept)
      mode <= ltmc_mode_t'(mode_wdata);
  end

  // [R14] bits stay wake-capable after a wake
  assign mode_bits = mode;

  ////////////////////////////////////////////////////////////////////////
  // [R15] enable period timer from normal entry
  // saturates, so enabled stays a level rather than a pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      en_cnt <= '0;
    else if (ce)
    begin
      if (mode != LTMC_NORMAL)
        en_cnt <= '0;
      else if (en_cnt != CNT_W'(EN_CYC))
        en_cnt <= en_cnt + 1'b1;
    end
  end

  assign enabled = (mode == LTMC_NORMAL) && (en_cnt == CNT_W'(EN_CYC));

  ////////////////////////////////////////////////////////////////////////
  // [R6] early dominant held off until tx returns high after enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_block <= 1'b1;
    else if (ce)
    begin
      if (!enabled)
        tx_block <= 1'b1;
      else if (tx_sync[1])
        tx_block <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [R7] [R16] bus driver; recessive outside normal mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_out <= 1'b1;
      bus_oe  <= 1'b0;
    end
    else if (ce)
    begin
      // open drain: only the enable moves, the level stays low
      bus_out <= 1'b0;
      bus_oe  <= enabled && !tx_block && !tx_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [R12] wake: fall, long dominant, rise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wk_cnt   <= '0;
      wk_armed <= 1'b0;
      wk_long  <= 1'b0;
    end
    else if (ce)
    begin
      if (mode != LTMC_WAKE || woken)
      begin
        wk_armed <= 1'b0;
        wk_long  <= 1'b0;
        wk_cnt   <= '0;
      end
      else if (fif.fall)
      begin
        wk_armed <= 1'b1;
        wk_long  <= 1'b0;
        wk_cnt   <= '0;
      end
      // rise ends a dominant; a short one must not leave its count armed
      else if (fif.rise)
      begin
        wk_armed <= 1'b0;
        wk_long  <= 1'b0;
        wk_cnt   <= '0;
      end
      else if (wk_armed && !fif.level)
      begin
        if (wk_cnt == CNT_W'(WAKE_CYC))
          wk_long <= 1'b1;
        else
          wk_cnt <= wk_cnt + 1'b1;
      end
    end
  end

  assign wake_pulse = ce && (mode == LTMC_WAKE) && !woken && wk_armed && wk_long && fif.rise;

  ////////////////////////////////////////////////////////////////////////
  // [R3] [R13] wake latch cleared by any accepted mode change, except when a wake pulse falls in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      woken <= 1'b0;
    else if (ce)
    begin
      if (wake_pulse)
        woken <= 1'b1;
      else if (mode_wr && accept && ltmc_mode_t'(mode_wdata) != mode)
        woken <= 1'b0;
      else if (mode == LTMC_OFF)
        woken <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [R8] receive output; idle high in off mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lin_receive_output <= 1'b1;
    else if (ce)
    begin
      // the wake flag wins over the mode so the host sees it first
      if (woken)
        lin_receive_output <= 1'b0;
      else if (mode == LTMC_NORMAL || mode == LTMC_RX_ONLY)
        lin_receive_output <= fif.level;
      else
        lin_receive_output <= 1'b1;
    end
  end
endmodule

//--- ltmc_pkg.sv
// Purpose: constants and types for the single-wire link transceiver mode control
// Assumes: 125 MHz clock, one transceiver
// Notes: timing figures kept in their own unit, cycle counts derived here
//
// Behaviour
// [R1] after reset the transceiver sits in off mode with driver and receiver idle.
// [R2] off mode may be selected whatever the chip operating mode is.
// [R3] in off mode bus wake activity is ignored and no wake is flagged.
// [R4] normal transceiver mode is accepted only while the chip is in its normal operating mode.
// [R5] the host keeps transmit input high until the enable time has elapsed.
// [R6] a low transmit input during enabling is not sent; only the next dominant bit after it is.
// [R7] in normal mode the bus is driven dominant while transmit input is low, else recessive.
// [R8] the filtered bus state is presented on the receive output.
// [R9] short noise pulses on the bus are filtered out before the receive output.
// [R10] the host picks the mode through two mode bits, one of them wake-capable.
// [R11] receive-only mode disables the driver but keeps reception, in chip normal and stop modes.
// [R12] in wake-capable mode a fall, a dominant longer than the wake filter time, then a rise is a wake.
// [R13] after a wake the receive output stays low until the host selects another mode.
// [R14] after a wake the mode bits still read the wake-capable code until rewritten.
// [R15] the enable period is timed from when normal mode takes effect and blocks sending.
// [R16] leaving normal mode forces the driver recessive whatever the transmit input is.
package ltmc_pkg;
  typedef enum logic [1:0] {
    LTMC_OFF     = 2'h0,
    LTMC_WAKE    = 2'h1,
    LTMC_RX_ONLY = 2'h2,
    LTMC_NORMAL  = 2'h3
  } ltmc_mode_t;

  typedef enum logic [1:0] {
    LTMC_CHIP_NORMAL  = 2'h0,
    LTMC_CHIP_STOP    = 2'h1,
    LTMC_CHIP_SLEEP   = 2'h2,
    LTMC_CHIP_RESTART = 2'h3
  } ltmc_chip_t;

  localparam int CLK_MHZ         = 125;
  // enable, wake filter and noise filter times, arbitrary plain defaults in us / ns
  localparam int EN_TIME_US      = 10;
  localparam int WAKE_FILT_US    = 30;
  localparam int NOISE_FILT_NS   = 1000;
  localparam int EN_CYC          = EN_TIME_US * CLK_MHZ;
  localparam int WAKE_CYC        = WAKE_FILT_US * CLK_MHZ;
  localparam int NOISE_CYC       = (NOISE_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W           = 13;
endpackage

//--- ltmc_filt_if.sv
`timescale 1ns/100ps
// Purpose: carries raw bus level into the noise filter and filtered level back
// Assumes: single clock domain
// Notes: none
interface ltmc_filt_if;
  logic raw;
  logic level;
  logic fall;
  logic rise;
  modport ctrl (output raw, input level, input fall, input rise);
  modport filt (input raw, output level, output fall, output rise);
endinterface

//--- ltmc_noise_filter.sv
`timescale 1ns/100ps
// Purpose: debounce the synchronised bus level
// Assumes: raw input already synchronised
// Notes: level only moves after NOISE_CYC stable samples
module ltmc_noise_filter
  import ltmc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // data
  ltmc_filt_if.filt f
);
  logic [CNT_W-1:0] cnt;
  logic             lvl;

  ////////////////////////////////////////////////////////////////////////
  // [R9] noise pulse rejection
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= '0;
      lvl <= 1'b1;
    end
    else if (ce)
    begin
      if (f.raw == lvl)
        cnt <= '0;
      else if (cnt == CNT_W'(NOISE_CYC - 1))
      begin
        cnt <= '0;
        lvl <= f.raw;
      end
      else
        cnt <= cnt + 1'b1;
    end
  end

  assign f.level = lvl;
  assign f.fall  = ce && lvl && !f.raw && (cnt == CNT_W'(NOISE_CYC - 1));
  assign f.rise  = ce && !lvl && f.raw && (cnt == CNT_W'(NOISE_CYC - 1));
endmodule

//--- ltmc_asserts.sv
// Purpose: port checks for ltmc_top
// Assumes: one clock, ce high in use
// Notes: counters give cycle figures
`timescale 1ns/100ps
module ltmc_asserts
  import ltmc_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  // mode
  input wire logic [1:0] chip_mode,
  input wire logic       mode_wr,
  input wire logic [1:0] mode_wdata,
  input wire logic [1:0] mode_bits,
  // data and status
  input wire logic       lin_transmit_input,
  input wire logic       lin_receive_output,
  input wire logic       bus_in,
  input wire logic       bus_oe,
  input wire logic       wake_pulse,
  input wire logic       enabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] en_cnt;
  logic [15:0] dom_cnt;
  logic [15:0] dom_len;
  logic        woke;
  wire         wr = mode_wr && ce;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst)
    if (rst || mode_bits != LTMC_NORMAL)
      en_cnt <= '0;
    else if (ce && en_cnt != 16'hFFFF)
      en_cnt <= en_cnt + 16'h0001;
  // raw length, filter shifts both edges alike
  always_ff @(posedge clk or posedge rst)
    if (rst || bus_in)
      dom_cnt <= '0;
    else
      dom_cnt <= dom_cnt + 16'h0001;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      dom_len <= '0;
    else if (bus_in && dom_cnt != '0)
      dom_len <= dom_cnt;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      woke <= 1'h0;
    else
      woke <= wake_pulse || (woke && mode_bits == LTMC_WAKE);
  ////////////////////////////////////////////////////////////
  sequence s_fall_enabled;
    $fell(lin_transmit_input) && $past(enabled, 8);
  endsequence
  sequence s_low_held;
    (enabled && !lin_transmit_input)[*4];
  endsequence
  a_dom_sent: assert property (s_fall_enabled ##1 s_low_held |-> bus_oe)
    else $error("dominant not driven");
  a_no_early: assert property (!enabled && !$past(enabled) |-> !bus_oe)
    else $error("driver on while not enabled");
  a_enable_wait: assert property (enabled |-> en_cnt >= EN_CYC - 2)
    else $error("enabled too soon");
  a_enable_done: assert property (en_cnt == EN_CYC + 4 |-> enabled)
    else $error("enable never done");
  a_norm_refused: assert property (wr && mode_wdata == LTMC_NORMAL &&
    chip_mode != LTMC_CHIP_NORMAL |=> $stable(mode_bits))
    else $error("normal taken outside chip normal");
  a_off_any: assert property (wr && mode_wdata == LTMC_OFF |=> mode_bits == LTMC_OFF)
    else $error("off refused");
  a_off_quiet: assert property (mode_bits == LTMC_OFF |-> !wake_pulse)
    else $error("wake in off mode");
  a_wake_len: assert property (wake_pulse |-> mode_bits == LTMC_WAKE &&
    dom_len >= WAKE_CYC - 2)
    else $error("wake without long dominant");
  // receive output is a register, so it goes low one cycle after the flag
  a_wake_hold: assert property (woke && $past(woke) && mode_bits == LTMC_WAKE
    |-> !lin_receive_output)
    else $error("receive output released");
  a_wake_code: assert property (wake_pulse && !wr |=> mode_bits == LTMC_WAKE)
    else $error("mode code lost on wake");
endmodule

//--- ltmc_bus_model.sv
// Purpose: single-wire bus with pull-up and a far node
// Assumes: low is dominant
// Notes: recessive whenever nobody pulls
`timescale 1ns/100ps
module ltmc_bus_model
(
  // pins
  input  wire logic bus_oe,
  input  wire logic far_dom,
  output logic      bus_lvl
);
  assign bus_lvl = !(bus_oe || far_dom);
endmodule

//--- ltmc_top_tb.sv
// Purpose: self-checking bench for ltmc_top
// Assumes: ce held high
// Notes: bench acts as host, far_dom as remote node
`timescale 1ns/100ps
module ltmc_top_tb
  import ltmc_pkg::*;
;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic       ce = 1'h1;
  logic [1:0] chip_mode = 2'h0;
  logic       mode_wr = 1'h0;
  logic [1:0] mode_wdata = 2'h0;
  logic       tx = 1'h1;
  logic       far_dom = 1'h0;
  logic [1:0] mode_bits;
  logic       rx, bus_lvl, bus_oe, wake_pulse, enabled;
  logic [3:0] n_wake = 4'h0;
  int         n_fail = 0;
  int         total_checks = 0;
  ltmc_top u_dut (.clk, .rst, .ce, .chip_mode, .mode_wr, .mode_wdata, .mode_bits,
    .lin_transmit_input(tx), .lin_receive_output(rx), .bus_in(bus_lvl), .bus_out(),
    .bus_oe, .wake_pulse, .enabled);
  ltmc_bus_model u_bus (.bus_oe, .far_dom, .bus_lvl);
  initial forever #4 clk = ~clk;
  always @(posedge clk)
    if (wake_pulse === 1'h1)
      n_wake <= n_wake + 4'h1;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [1:0] code);
    mode_wr = 1'h1;
    mode_wdata = code;
    cyc(1);
    mode_wr = 1'h0;
    cyc(1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // mode selection
  task automatic t_modes;
    chk({mode_bits, rx, bus_oe, enabled}, 8'h04);
    chip_mode = LTMC_CHIP_STOP;
    wr(LTMC_NORMAL);
    chk(mode_bits, LTMC_OFF);
    wr(LTMC_RX_ONLY);
    chk(mode_bits, LTMC_RX_ONLY);
    chip_mode = LTMC_CHIP_SLEEP;
    wr(LTMC_OFF);
    chk(mode_bits, LTMC_OFF);
    wr(LTMC_WAKE);
    chk(mode_bits, LTMC_WAKE);
  endtask
  task automatic t_rx;
    chip_mode = LTMC_CHIP_NORMAL;
    wr(LTMC_RX_ONLY);
    tx = 1'h0;
    far_dom = 1'h1;
    cyc(NOISE_CYC / 2);
    far_dom = 1'h0;
    cyc(NOISE_CYC * 2);
    chk(rx, 1'h1);
    far_dom = 1'h1;
    cyc(NOISE_CYC * 2);
    chk({rx, bus_oe}, 2'h0);
    far_dom = 1'h0;
    tx = 1'h1;
    cyc(NOISE_CYC * 2);
    chk(rx, 1'h1);
  endtask
  task automatic t_enable;
    wr(LTMC_NORMAL);
    tx = 1'h0;
    cyc(EN_CYC + 20);
    chk({enabled, bus_oe}, 2'h2);
    // host now keeps the enable rule: high first, then the dominant bit
    tx = 1'h1;
    cyc(4);
    chk(bus_oe, 1'h0);
    tx = 1'h0;
    cyc(5);
    chk(bus_oe, 1'h1);
    cyc(NOISE_CYC * 2);
    chk(rx, 1'h0);
    wr(LTMC_OFF);
    chk(bus_oe, 1'h0);
    tx = 1'h1;
  endtask
  task automatic t_wake;
    int i;
    far_dom = 1'h1;
    cyc(WAKE_CYC + 100);
    far_dom = 1'h0;
    cyc(NOISE_CYC * 3);
    chk({n_wake, rx}, 8'h01);
    wr(LTMC_WAKE);
    far_dom = 1'h1;
    cyc(WAKE_CYC - 500);
    far_dom = 1'h0;
    cyc(NOISE_CYC * 3);
    chk(n_wake, 4'h0);
    far_dom = 1'h1;
    cyc(WAKE_CYC + 100);
    far_dom = 1'h0;
    for (i = 0; i < 400 && n_wake == 4'h0; i++)
      cyc(1);
    chk(n_wake, 4'h1);
    if (i == 400)
      conclude;
    cyc(50);
    chk({mode_bits, rx}, 3'h2);
    wr(LTMC_RX_ONLY);
    cyc(2);
    chk(rx, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    cyc(20);
    rst = 1'h0;
    cyc(1);
    t_modes;
    t_rx;
    t_enable;
    t_wake;
    conclude;
  end
endmodule
bind ltmc_top ltmc_asserts u_chk (.clk, .rst, .ce, .chip_mode, .mode_wr, .mode_wdata,
  .mode_bits, .lin_transmit_input, .lin_receive_output, .bus_in, .bus_oe, .wake_pulse,
  .enabled);
